// File: rtl/sgs_standby_glue.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgs_defines.svh"

module sgs_standby_glue
   import sgs_pkg::*;
#(
   parameter int RESET_DELAY_CYCLES = `SGS_RESET_DELAY_US * `SGS_CLK_MHZ,
   parameter int CNT_W = `SGS_DELAY_CNT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Chipset sleep and supply inputs
   input wire logic supplyGoodIn,
   input wire logic suspendSleepN,
   input wire logic softOffSleepN,
   // Standby rail detectors
   input wire logic standby5vRail,
   input wire logic standby3v3Rail,
   // Codec link
   input wire logic audioLinkResetN,
   output logic codecDisableResetN,
   // Shared GPIO pin
   input wire logic sharedGpioIn,
   output logic sharedGpioOut,
   output logic sharedGpioOe,
   // Supply switching outputs
   output logic supplySwitchCutNOut,
   output logic supplySwitchCutNOe,
   output logic latchedSupplyCut,
   // Resume well reset
   output logic resumeWellResetN,
   // Avalon-MM slave
   input wire logic [`SGS_ADDR_W-1:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWriteData,
   input wire logic [3:0] avsByteEnable,
   output logic [31:0] avsReadData,
   output logic avsWaitrequest
);

   localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(RESET_DELAY_CYCLES - 1);

   if (RESET_DELAY_CYCLES < 1 || RESET_DELAY_CYCLES > 2 ** CNT_W) begin : gChk
      $error("sgs_standby_glue: delay does not fit the counter width");
   end

   logic [`SGS_IN_NUM-1:0] inFilt;
   logic [`SGS_CTRL_W-1:0] ctrl;
   logic prevCutN;
   logic cutN;
   logic codecEnN;
   logic gpioLevel;
   logic [CNT_W-1:0] delayCnt;
   sgs_rsm_state_t rsmState;
   sgs_rsm_state_t next_rsmState;
   logic [`SGS_ST_W-1:0] status;

   // All pins are outside this clock, so each passes the filter chain
   sgs_pin_if #(.W(`SGS_IN_NUM)) pinBus ();

   assign pinBus.raw[`SGS_IN_GOOD] = supplyGoodIn;
   assign pinBus.raw[`SGS_IN_S3] = suspendSleepN;
   assign pinBus.raw[`SGS_IN_S5] = softOffSleepN;
   assign pinBus.raw[`SGS_IN_5V] = standby5vRail;
   assign pinBus.raw[`SGS_IN_3V3] = standby3v3Rail;
   assign pinBus.raw[`SGS_IN_ALINK] = audioLinkResetN;
   assign pinBus.raw[`SGS_IN_GPIO] = sharedGpioIn;
   assign inFilt = pinBus.filt;

   sgs_pin_sync #(
      .W(`SGS_IN_NUM),
      .RST_VAL(`SGS_IN_RST)
   ) sgs_pin_sync_i (
      .clk(clk),
      .rst_b(rst_b),
      .pins(pinBus)
   );

   // Supply cut: open drain, data always low, only the enable moves
   // drive when both high
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         supplySwitchCutNOut <= 1'b0;
         supplySwitchCutNOe <= 1'b0;
      end else begin
         supplySwitchCutNOut <= 1'b0;
         supplySwitchCutNOe <= inFilt[`SGS_IN_GOOD] & inFilt[`SGS_IN_S3];
      end
   end

   // Pin level as seen with the external pull-up
   assign cutN = ~supplySwitchCutNOe;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prevCutN <= 1'b0;
      end else begin
         prevCutN <= cutN;
      end
   end

   // Latched cut; a release seen before S5 rises is not latched later
   // set on rise, clear on S5
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latchedSupplyCut <= 1'b0;
      end else if (!inFilt[`SGS_IN_S5] || !cutN) begin
         latchedSupplyCut <= 1'b0;
      end else if (!prevCutN) begin
         latchedSupplyCut <= 1'b1;
      end
   end

   // Resume reset sequencer
   // restart only from rail down
   always_comb begin
      next_rsmState = rsmState;
      case (rsmState)
         SGS_RAIL_DOWN: begin
            if (inFilt[`SGS_IN_5V]) begin
               next_rsmState = SGS_DELAY;
            end
         end
         SGS_DELAY: begin
            if (delayCnt == DELAY_LAST) begin
               next_rsmState = SGS_WAIT_3V3;
            end
         end
         SGS_WAIT_3V3: begin
            if (inFilt[`SGS_IN_3V3]) begin
               next_rsmState = SGS_RELEASED;
            end
         end
         SGS_RELEASED: begin
            next_rsmState = SGS_RELEASED;
         end
         default: begin
            next_rsmState = SGS_RAIL_DOWN;
         end
      endcase
      if (!inFilt[`SGS_IN_5V]) begin
         next_rsmState = SGS_RAIL_DOWN;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsmState <= SGS_RAIL_DOWN;
      end else begin
         rsmState <= next_rsmState;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         delayCnt <= '0;
      end else if (rsmState == SGS_DELAY && delayCnt != DELAY_LAST) begin
         delayCnt <= delayCnt + 1'b1;
      end else if (rsmState == SGS_RAIL_DOWN) begin
         delayCnt <= '0;
      end
   end

   // hold low until 3.3 V present
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resumeWellResetN <= 1'b0;
      end else begin
         resumeWellResetN <= (next_rsmState == SGS_RELEASED) &
                             inFilt[`SGS_IN_3V3];
      end
   end

   // Codec enable source selected by the pin control register
   // direct pin feed in codec mode
   always_comb begin
      gpioLevel = ctrl[`SGS_CTRL_DATA] ^ ctrl[`SGS_CTRL_POL];
      if (ctrl[`SGS_CTRL_FUNC]) begin
         codecEnN = inFilt[`SGS_IN_GPIO];
      end else if (ctrl[`SGS_CTRL_DIR]) begin
         codecEnN = gpioLevel;
      end else begin
         codecEnN = 1'b0;
      end
   end

   // no sleep input gates this path
   // reset is link AND not enable
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         codecDisableResetN <= 1'b0;
      end else begin
         codecDisableResetN <= inFilt[`SGS_IN_ALINK] & ~codecEnN;
      end
   end

   // Pin driver; open drain only ever pulls low
   // polarity and type on pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sharedGpioOut <= 1'b0;
         sharedGpioOe <= 1'b0;
      end else if (!ctrl[`SGS_CTRL_FUNC] && ctrl[`SGS_CTRL_DIR]) begin
         sharedGpioOut <= gpioLevel & ~ctrl[`SGS_CTRL_OD];
         sharedGpioOe <= ~(ctrl[`SGS_CTRL_OD] & gpioLevel);
      end else begin
         sharedGpioOut <= 1'b0;
         sharedGpioOe <= 1'b0;
      end
   end

   // Bus answer: one wait cycle, then a single low waitrequest cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avsWaitrequest <= 1'b1;
      end else begin
         avsWaitrequest <= !((avsRead | avsWrite) & avsWaitrequest);
      end
   end

   // Control register, taken at the edge where waitrequest is low
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= `SGS_CTRL_RST;
      end else if (avsWrite && !avsWaitrequest && avsByteEnable[0] &&
                   avsAddress == `SGS_REG_CTRL) begin
         ctrl <= avsWriteData[`SGS_CTRL_W-1:0];
      end
   end

   assign status = {codecEnN, inFilt[`SGS_IN_GPIO], codecDisableResetN,
                    resumeWellResetN, supplySwitchCutNOe, latchedSupplyCut};

   // Read data loaded with the answer; unmapped words read zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avsReadData <= '0;
      end else if (avsRead && avsWaitrequest) begin
         case (avsAddress)
            `SGS_REG_CTRL: avsReadData <= 32'(ctrl);
            `SGS_REG_STATUS: avsReadData <= 32'(status);
            default: avsReadData <= '0;
         endcase
      end
   end

   // Cycles since the 5 V rail came up, checking aid only
   logic [31:0] railUpCnt;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         railUpCnt <= '0;
      end else if (!inFilt[`SGS_IN_5V]) begin
         railUpCnt <= '0;
      end else if (railUpCnt != 32'hffffffff) begin
         railUpCnt <= railUpCnt + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   supply_cut_drive_a: assert property (
      supplySwitchCutNOe |->
         $past(inFilt[`SGS_IN_GOOD]) && $past(inFilt[`SGS_IN_S3]))
      else $error("supply cut driven without both inputs high");

   s3_release_a: assert property (
      !inFilt[`SGS_IN_S3] |=> !supplySwitchCutNOe [*1] ##0 cutN)
      else $error("supply cut not released after S3 low");

   latch_set_a: assert property (
      (cutN && !prevCutN && inFilt[`SGS_IN_S5]) |=> latchedSupplyCut)
      else $error("latched cut missed a rising edge");

   latch_clear_a: assert property (
      (!inFilt[`SGS_IN_S5] || !cutN) |=> !latchedSupplyCut)
      else $error("latched cut high with an input low");

   latch_hold_a: assert property (
      (latchedSupplyCut && cutN && inFilt[`SGS_IN_S5]) |=> latchedSupplyCut)
      else $error("latched cut dropped without cause");

   rsm_delay_a: assert property (
      $rose(resumeWellResetN) |-> railUpCnt >= 32'(RESET_DELAY_CYCLES))
      else $error("resume reset released before the delay");

   rsm_vtr_a: assert property (
      !inFilt[`SGS_IN_3V3] |=> !resumeWellResetN)
      else $error("resume reset released without 3.3 V");

   rsm_fall_a: assert property (
      $fell(inFilt[`SGS_IN_5V]) |=> !resumeWellResetN ##1 delayCnt == '0)
      else $error("resume reset late on rail drop");

   codec_reset_a: assert property (
      codecDisableResetN ==
         ($past(inFilt[`SGS_IN_ALINK]) && !$past(codecEnN)))
      else $error("codec reset does not follow link and enable");

   codec_func_a: assert property (
      ctrl[`SGS_CTRL_FUNC] |-> codecEnN == inFilt[`SGS_IN_GPIO])
      else $error("codec enable not taken from the pin");

   gpio_out_a: assert property (
      (!ctrl[`SGS_CTRL_FUNC] && ctrl[`SGS_CTRL_DIR]) |->
         codecEnN == (ctrl[`SGS_CTRL_DATA] ^ ctrl[`SGS_CTRL_POL]))
      else $error("codec enable not following data and polarity");

   gpio_in_a: assert property (
      (!ctrl[`SGS_CTRL_FUNC] && !ctrl[`SGS_CTRL_DIR]) |-> !codecEnN)
      else $error("GPIO input affected the codec enable");

   bus_ack_a: assert property (
      !avsWaitrequest |=> avsWaitrequest)
      else $error("waitrequest low for more than one cycle");

   latch_set_c: cover property ($rose(latchedSupplyCut));
   rsm_release_c: cover property ($rose(resumeWellResetN));
   codec_run_c: cover property ($rose(codecDisableResetN));
   bus_write_c: cover property (avsWrite && !avsWaitrequest);

endmodule

`default_nettype wire

// File: common/sgs_defines.svh
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH

// Clock rate and resume reset release delay
`define SGS_CLK_MHZ 200
`define SGS_RESET_DELAY_US 32000
`define SGS_DELAY_CNT_W 23

// Bit positions of the synchronised input vector
`define SGS_IN_GOOD 0
`define SGS_IN_S3 1
`define SGS_IN_S5 2
`define SGS_IN_5V 3
`define SGS_IN_3V3 4
`define SGS_IN_ALINK 5
`define SGS_IN_GPIO 6
`define SGS_IN_NUM 7
`define SGS_IN_RST 7'h00

// Register byte offsets
`define SGS_ADDR_W 4
`define SGS_REG_CTRL 4'h0
`define SGS_REG_STATUS 4'h4

// Pin control register fields
`define SGS_CTRL_FUNC 0
`define SGS_CTRL_DIR 1
`define SGS_CTRL_POL 2
`define SGS_CTRL_OD 3
`define SGS_CTRL_DATA 4
`define SGS_CTRL_W 5
`define SGS_CTRL_RST 5'h01

// Status register fields
`define SGS_ST_LATCH 0
`define SGS_ST_CUT 1
`define SGS_ST_RSM 2
`define SGS_ST_CODEC 3
`define SGS_ST_PIN 4
`define SGS_ST_ENAB 5
`define SGS_ST_W 6

`endif

// File: common/sgs_pkg.sv
package sgs_pkg;

   // Resume reset sequencer, Gray coded along the power-up path
   typedef enum logic [1:0] {
      SGS_RAIL_DOWN = 2'h0,
      SGS_DELAY = 2'h1,
      SGS_WAIT_3V3 = 2'h3,
      SGS_RELEASED = 2'h2
   } sgs_rsm_state_t;

endpackage

// File: common/sgs_pin_if.sv
`timescale 1ns/1ps
`default_nettype none

// Raw pin levels in, filtered levels out
interface sgs_pin_if #(
   parameter int W = 1
);
   logic [W-1:0] raw;
   logic [W-1:0] filt;

   modport sync (input raw, output filt);
   modport user (output raw, input filt);
endinterface

`default_nettype wire

// File: rtl/sgs_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sgs_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin levels
   sgs_pin_if.sync pins
);

   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   if (W < 1) begin : gWidthCheck
      $error("sgs_pin_sync: width must be at least one");
   end

   // Three-stage chain; only stage2 reads stage1
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
         stage3 <= RST_VAL;
      end else begin
         stage1 <= pins.raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pins.filt <= RST_VAL;
      end else begin
         pins.filt <= (stage2 & stage3) | (pins.filt & (stage2 | stage3));
      end
   end

endmodule

`default_nettype wire

// File: dv/sgs_chipset_model.sv
`timescale 1ns/1ps
`default_nettype none

// Chipset side: sleep, supply good and link reset levels
module sgs_chipset_model #(
   parameter int T3_CYCLES = 6000
) (
   // Clock
   input wire logic clk,
   // Levels toward the block
   output logic supplyGood,
   output logic suspendSleepN,
   output logic softOffSleepN,
   output logic audioLinkResetN
);
   // Everything asleep at power-up
   initial begin
      supplyGood = 1'b0;
      suspendSleepN = 1'b0;
      softOffSleepN = 1'b0;
      audioLinkResetN = 1'b0;
   end

   // Set all four levels just after a rising edge
   task automatic setLevels(input logic [3:0] lv);
      @(posedge clk);
      {supplyGood, suspendSleepN, softOffSleepN, audioLinkResetN} <= lv;
   endtask

   // Normal power-down, S5 trails S3 by t3 as the chipset does
   task automatic powerDown();
      @(posedge clk);
      suspendSleepN <= 1'b0;
      repeat (T3_CYCLES) @(posedge clk);
      softOffSleepN <= 1'b0;
   endtask
endmodule

`default_nettype wire

// File: dv/sgs_standby_glue_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sgs_defines.svh"

module sgs_standby_glue_tb;
   import sgs_pkg::*;
   // Short delay keeps the run brief
   localparam int DELAY = 20;
   // {ctrl, enable from pin, enable value, pin driven, pin value}
   localparam logic [11:0] CASES [8] = '{12'h018, 12'h058, 12'h022,
      12'h127, 12'h162, 12'h1a4, 12'h0a2, 12'h000};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic rail5v = 1'b0;
   logic rail3v3 = 1'b0;
   logic extPin = 1'b1;
   logic [3:0] avsAddress = '0;
   logic avsRead = 1'b0;
   logic avsWrite = 1'b0;
   logic [31:0] avsWriteData = '0;
   logic [3:0] avsByteEnable = '0;
   logic [31:0] avsReadData;
   logic avsWaitrequest;
   logic good, s3n, s5n, linkN, pinIn, pinOut, pinOe, cutOut, cutOe;
   logic latched, codecN, rsmN;
   int failCount = 0;
   int checked = 0;

   // Clock at 200 MHz
   always #2.5 clk = ~clk;

   // Shared pin: design drive wins over the board level
   assign pinIn = pinOe ? pinOut : extPin;

   sgs_chipset_model #(.T3_CYCLES(20)) sgs_chipset_model_i (.clk(clk),
      .supplyGood(good), .suspendSleepN(s3n), .softOffSleepN(s5n),
      .audioLinkResetN(linkN));

   sgs_standby_glue #(.RESET_DELAY_CYCLES(DELAY)) sgs_standby_glue_i (
      .clk(clk), .rst_b(rst_b), .supplyGoodIn(good), .suspendSleepN(s3n),
      .softOffSleepN(s5n), .standby5vRail(rail5v),
      .standby3v3Rail(rail3v3), .audioLinkResetN(linkN),
      .codecDisableResetN(codecN), .sharedGpioIn(pinIn),
      .sharedGpioOut(pinOut), .sharedGpioOe(pinOe),
      .supplySwitchCutNOut(cutOut), .supplySwitchCutNOe(cutOe),
      .latchedSupplyCut(latched), .resumeWellResetN(rsmN),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
      .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Let n edges pass, then look once values have settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One Avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd, input logic [3:0] be,
                      output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      avsAddress <= a;
      avsWrite <= wr;
      avsRead <= !wr;
      avsWriteData <= wd;
      avsByteEnable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avsWaitrequest !== 1'b0 && n < 50);
      rd = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      check("bus answer", n < 50, 1'b1);
   endtask

   task automatic report_and_stop();
      $display("Checks made %0d, mismatches %0d", checked, failCount);
      if (failCount == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Outputs and control register straight after reset
   task automatic testReset();
      logic [31:0] rd;
      settle(2);
      check("latched at start", latched, 1'b0);
      check("resume at start", rsmN, 1'b0);
      bus(1'b0, `SGS_REG_CTRL, '0, 4'hf, rd);
      check("ctrl reset", rd, 32'h01);
   endtask

   // Supply cut drive over all good/S3 combinations
   task automatic testCutTable();
      for (int i = 0; i < 4; i++) begin
         sgs_chipset_model_i.setLevels({i[1], i[0], 2'b01});
         settle(8);
         check("cut drive", cutOe, i[1] & i[0]);
         check("cut level", cutOut, 1'b0);
         check("latched S5 low", latched, 1'b0);
      end
   endtask

   // Normal power-down, then S5 back up with no new cut edge
   task automatic testPowerDown();
      sgs_chipset_model_i.setLevels(4'hf);
      settle(8);
      check("latched idle", latched, 1'b0);
      fork
         sgs_chipset_model_i.powerDown();
         begin
            settle(10);
            check("cut released", cutOe, 1'b0);
            check("latched set", latched, 1'b1);
         end
      join
      settle(8);
      check("latched cleared", latched, 1'b0);
      sgs_chipset_model_i.setLevels(4'b1011);
      settle(8);
      check("latched holds", latched, 1'b0);
      sgs_chipset_model_i.setLevels(4'hf);
      settle(8);
      check("cut back", cutOe, 1'b1);
      check("latched off", latched, 1'b0);
   endtask

   // Reset in mid-run with S5 high and the cut released must not latch
   task automatic testMidReset();
      sgs_chipset_model_i.setLevels(4'b1011);
      settle(8);
      check("latched before reset", latched, 1'b1);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      settle(2);
      check("latched after reset", latched, 1'b0);
      check("cut after reset", cutOe, 1'b0);
      settle(8);
      check("latched stays off", latched, 1'b0);
      sgs_chipset_model_i.setLevels(4'hf);
      settle(8);
      check("cut after restart", cutOe, 1'b1);
   endtask

   // Resume reset delay, brown-out, late 3.3 V and 3.3 V loss
   task automatic testResume();
      @(posedge clk);
      rail3v3 <= 1'b1;
      rail5v <= 1'b1;
      settle(15);
      check("resume in delay", rsmN, 1'b0);
      settle(20);
      check("resume released", rsmN, 1'b1);
      @(posedge clk);
      rail5v <= 1'b0;
      settle(6);
      check("resume brown-out", rsmN, 1'b0);
      @(posedge clk);
      rail3v3 <= 1'b0;
      rail5v <= 1'b1;
      settle(40);
      check("resume waits 3v3", rsmN, 1'b0);
      @(posedge clk);
      rail3v3 <= 1'b1;
      settle(6);
      check("resume on 3v3", rsmN, 1'b1);
      @(posedge clk);
      rail3v3 <= 1'b0;
      settle(6);
      check("resume 3v3 loss", rsmN, 1'b0);
      @(posedge clk);
      rail3v3 <= 1'b1;
      settle(6);
      check("no second delay", rsmN, 1'b1);
   endtask

   // Codec reset in every pin mode, with both sleeps asserted
   task automatic testCodec();
      logic [31:0] rd;
      logic [11:0] c;
      logic en;
      for (int k = 0; k < 8; k++) begin
         c = CASES[k];
         bus(1'b1, `SGS_REG_CTRL, {24'h0, c[11:4]}, 4'h1, rd);
         bus(1'b0, `SGS_REG_CTRL, '0, 4'hf, rd);
         check("ctrl readback", rd, {24'h0, c[11:4]});
         for (int j = 0; j < 4; j++) begin
            sgs_chipset_model_i.setLevels({3'b000, j[0]});
            extPin <= j[1];
            settle(8);
            en = c[3] ? j[1] : c[2];
            check("codec reset", codecN, j[0] & ~en);
            check("pin driven", pinOe, c[1]);
            if (c[1]) begin
               check("pin value", pinOut, c[0]);
            end
         end
      end
   endtask

   // Unmapped read, read-only status, byte lane refused
   task automatic testRefused();
      logic [31:0] rd;
      logic [31:0] prior;
      bus(1'b0, 4'h8, '0, 4'hf, rd);
      check("unmapped read", rd, 32'h0);
      bus(1'b0, `SGS_REG_STATUS, '0, 4'hf, prior);
      bus(1'b1, `SGS_REG_STATUS, 32'hffffffff, 4'hf, rd);
      bus(1'b0, `SGS_REG_STATUS, '0, 4'hf, rd);
      check("status read only", rd, prior);
      bus(1'b1, `SGS_REG_CTRL, 32'h1f, 4'h0, rd);
      bus(1'b0, `SGS_REG_CTRL, '0, 4'hf, rd);
      check("lane ignored", rd, 32'h00);
   endtask

   // Reset, then every scenario in turn
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      testReset();
      testCutTable();
      testPowerDown();
      testMidReset();
      testResume();
      testCodec();
      testRefused();
      report_and_stop();
   end

   // Watchdog well past the few hundred cycles the run needs
   initial begin
      #100000;
      failCount++;
      report_and_stop();
   end
endmodule

`default_nettype wire
